// *** rtl/tmfr_pkg.sv ***
package tmfr_pkg;
   // Clock and timing
   localparam int CLK_HZ          = 20_000_000;
   localparam int CONV_PERIOD_MS  = 1000;
   localparam int RST_TIMEOUT_MS  = 180;
   localparam int CONV_CYCLES     = CLK_HZ / 1000 * CONV_PERIOD_MS;
   localparam int RST_CYCLES      = CLK_HZ / 1000 * RST_TIMEOUT_MS;
   localparam int ALARM_CYCLES    = 3;
   localparam int STRAP_WAIT      = 3;

   // Register offsets
   localparam logic [7:0] OFS_REMOTE_TEMP  = 8'h20;
   localparam logic [7:0] OFS_LOCAL_TEMP   = 8'h21;
   localparam logic [7:0] OFS_REMOTE_LIMIT = 8'h22;
   localparam logic [7:0] OFS_LOCAL_LIMIT  = 8'h23;
   localparam logic [7:0] OFS_FAN_SPEED    = 8'h24;
   localparam logic [7:0] OFS_CONFIG       = 8'h40;
   localparam logic [7:0] OFS_STATUS       = 8'h41;
   localparam logic [7:0] OFS_MASK         = 8'h42;

   // Configuration fields
   localparam int CFG_INT_EN  = 1;
   localparam int CFG_FAN_ON  = 5;
   localparam int CFG_GIN_INV = 6;

   // Status fields
   localparam int ST_REMOTE_HI = 0;
   localparam int ST_LOCAL_HI  = 1;
   localparam int ST_DEF_TRIP  = 2;
   localparam int ST_EXT_ALARM = 3;
   localparam int ST_GIN       = 4;
   localparam int ST_EVENTS    = 4;

   // Reset values
   localparam logic [7:0] CONFIG_RST   = 8'h20;
   localparam logic [7:0] MASK_RST     = 8'h00;
   localparam logic [7:0] FAN_RST      = 8'h00;
   localparam logic [7:0] LIMIT_RST    = 8'h46;
   localparam logic [7:0] DEF_LIMIT    = 8'h55;
   localparam logic [7:0] DAC_FULL     = 8'hff;
   localparam logic [7:0] DAC_ZERO     = 8'h00;

   // Address: upper five bits arbitrary, bit 1 zero, bit 0 from the strap
   localparam logic [4:0] SMB_ADDR_HI  = 5'h0b;

   typedef enum logic [3:0] {
      SMB_IDLE    = 4'h0,
      SMB_ADDR    = 4'h1,
      SMB_ADDR_ACK = 4'h3,
      SMB_PTR     = 4'h2,
      SMB_PTR_ACK = 4'h6,
      SMB_WR      = 4'h7,
      SMB_WR_ACK  = 4'h5,
      SMB_RD      = 4'h4,
      SMB_RD_ACK  = 4'hc
   } tmfr_smb_e;
endpackage

// *** rtl/tmfr_rst_if.sv ***
interface tmfr_rst_if;
   logic req;
   logic active;
   modport gen (input req, output active);
   modport mon (output req, input active);
endinterface

// *** rtl/tmfr_reset_stretch.sv ***
module tmfr_reset_stretch
   import tmfr_pkg::*;
#(
   parameter int HOLD_CYCLES = RST_CYCLES
) (
   // Clock and reset
   input  wire logic clk_in,
   input  wire logic rst_in,
   // Request and stretched level
   tmfr_rst_if.gen   rif
);
   localparam int CW = $clog2(HOLD_CYCLES + 1);
   localparam logic [CW-1:0] HOLD_LAST = CW'(HOLD_CYCLES - 1);

   logic [CW-1:0] cnt_reg;

   // Asserted while requested, then held for the timeout
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cnt_reg    <= '0;
         rif.active <= 1'b1;
      end else if (rif.req) begin
         cnt_reg    <= '0;
         rif.active <= 1'b1;
      end else if (rif.active) begin
         if (cnt_reg == HOLD_LAST) begin
            rif.active <= 1'b0;
         end else begin
            cnt_reg <= cnt_reg + 1'b1;
         end
      end
   end
endmodule

// *** rtl/tmfr_top.sv ***
// How it works
// - Temperature words are 8-bit two's complement, compared signed.
// - Limit violations set sticky status; unmasked ones pull the interrupt low.
// - Interrupt output works only with config bit 1 set; cleared at reset.
// - Alarm pin driven low after three consecutive over-default conversions.
// - Outside main reset, exceeding a default limit forces the fan code to full scale.
// - External low on the alarm pin sets status and holds fan full scale.
// - Fan-off request pin follows config bit 5; fan code untouched.
// - Status bit 4 shows general input, inverted when config bit 6 set.
// - Manual reset low asserts main reset, held about 180 ms after release.
// - Main reset from low supply, manual reset or aux reset, then timeout.
// - Aux reset follows low aux supply plus timeout; pin may be pulled externally.
// - During main reset fan code is zero, or all ones with alarm low.
// - Address strap sampled once after power-on sets address bit 0; bit 1 is zero.
// - Fan pin high at power-up selects NAND-tree test on the strap pin.
// - One conversion per second from a cycle counter.
module tmfr_top
   import tmfr_pkg::*;
#(
   parameter int         CONV_CYCLES_P = CONV_CYCLES,
   parameter int         RST_CYCLES_P  = RST_CYCLES,
   parameter logic [7:0] DEF_LIMIT_P   = DEF_LIMIT
) (
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   // Converter results
   input  wire logic [7:0] remote_temp_in,
   input  wire logic [7:0] local_temp_in,
   // SMBus
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_out,
   // Thermal alarm pin
   input  wire logic       overtemp_alarm_n_in,
   output logic            overtemp_alarm_n_out,
   output logic            overtemp_alarm_n_oe_out,
   // Fan control, interrupt and general input
   output logic [7:0]      fan_speed_dac_out,
   output logic            fan_dac_oe_out,
   input  wire logic       fan_dac_test_in,
   output logic            fan_off_n_out,
   output logic            int_n_out,
   input  wire logic       general_input_in,
   // Strap and test pin
   input  wire logic       addr_strap_test_in,
   output logic            addr_strap_test_out,
   output logic            addr_strap_test_oe_out,
   // Supervisors
   input  wire logic       main_supply_monitor_in,
   input  wire logic       aux_supply_in,
   input  wire logic       manual_reset_n_in,
   input  wire logic       aux_reset_n_in,
   output logic            aux_reset_n_out,
   output logic            aux_reset_n_oe_out,
   output logic            main_reset_n_out
);
   localparam int CCW = $clog2(CONV_CYCLES_P + 1);
   localparam logic [CCW-1:0] CONV_LAST = CCW'(CONV_CYCLES_P - 1);

   // Pin synchronisers
   localparam int NS = 10;
   logic [NS-1:0] sync1_reg;
   logic [NS-1:0] sync2_reg;
   always_ff @(posedge clk_in) begin
      sync1_reg <= {scl_in, sda_in, overtemp_alarm_n_in, aux_reset_n_in, manual_reset_n_in,
                    main_supply_monitor_in, aux_supply_in, general_input_in,
                    addr_strap_test_in, fan_dac_test_in};
      sync2_reg <= sync1_reg;
   end
   logic s_scl, s_sda, s_alarm_n, s_aux_n, s_man_n, s_main_ok, s_aux_ok, s_gin, s_strap, s_test;
   assign {s_scl, s_sda, s_alarm_n, s_aux_n, s_man_n, s_main_ok, s_aux_ok, s_gin, s_strap,
           s_test} = sync2_reg;

   // Registers
   logic [7:0] cfg_reg, mask_reg, fan_reg, rlim_reg, llim_reg, rtemp_reg, ltemp_reg;
   logic [ST_EVENTS-1:0] stat_reg;
   logic        wr_stb, rd_stb;
   logic [7:0]  ptr_reg, wdata_reg, rdata;

   // Power-on strap capture
   logic [1:0] strap_cnt_reg;
   logic       strap_done_reg, addr_lsb_reg, test_mode_reg;
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         strap_cnt_reg  <= 2'h0;
         strap_done_reg <= 1'b0;
         addr_lsb_reg   <= 1'b0;
         test_mode_reg  <= 1'b0;
      end else if (!strap_done_reg) begin
         strap_cnt_reg <= strap_cnt_reg + 2'h1;
         if (strap_cnt_reg == 2'(STRAP_WAIT)) begin
            strap_done_reg <= 1'b1;
            addr_lsb_reg   <= s_strap;
            test_mode_reg  <= s_test;
         end
      end
   end

   // Conversion tick and result capture
   logic [CCW-1:0] conv_cnt_reg;
   logic           tick_reg;
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         conv_cnt_reg <= '0;
         tick_reg     <= 1'b0;
         rtemp_reg    <= 8'h00;
         ltemp_reg    <= 8'h00;
      end else begin
         tick_reg <= (conv_cnt_reg == CONV_LAST);
         conv_cnt_reg <= (conv_cnt_reg == CONV_LAST) ? '0 : conv_cnt_reg + 1'b1;
         if (conv_cnt_reg == CONV_LAST) begin
            rtemp_reg <= remote_temp_in;
            ltemp_reg <= local_temp_in;
         end
      end
   end

   logic remote_hi, local_hi, def_trip;
   assign remote_hi = $signed(rtemp_reg) > $signed(rlim_reg);
   assign local_hi  = $signed(ltemp_reg) > $signed(llim_reg);
   assign def_trip  = ($signed(rtemp_reg) > $signed(DEF_LIMIT_P)) ||
                      ($signed(ltemp_reg) > $signed(DEF_LIMIT_P));

   // Alarm pin drive after three consecutive trips
   logic [1:0] trip_cnt_reg;
   logic       alarm_oe_reg;
   logic [2:0] alarm_oe_hist_reg;
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         trip_cnt_reg      <= 2'h0;
         alarm_oe_reg      <= 1'b0;
         alarm_oe_hist_reg <= 3'h0;
      end else begin
         alarm_oe_hist_reg <= {alarm_oe_hist_reg[1:0], alarm_oe_reg};
         if (tick_reg) begin
            if (!def_trip) begin
               trip_cnt_reg <= 2'h0;
               alarm_oe_reg <= 1'b0;
            end else if (trip_cnt_reg == 2'(ALARM_CYCLES - 1)) begin
               alarm_oe_reg <= 1'b1;
            end else begin
               trip_cnt_reg <= trip_cnt_reg + 2'h1;
            end
         end
      end
   end

   logic ext_alarm, alarm_low;
   assign ext_alarm = !s_alarm_n && !alarm_oe_reg && (alarm_oe_hist_reg == 3'h0);
   assign alarm_low = !s_alarm_n || alarm_oe_reg;

   // Sticky status; a new event wins over the read clear
   logic [ST_EVENTS-1:0] stat_set;
   assign stat_set = {ext_alarm, alarm_oe_reg, local_hi, remote_hi};
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         stat_reg <= '0;
      end else begin
         stat_reg <= (rd_stb && ptr_reg == OFS_STATUS ? '0 : stat_reg) | stat_set;
      end
   end

   // Register writes
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cfg_reg  <= CONFIG_RST;
         mask_reg <= MASK_RST;
         fan_reg  <= FAN_RST;
         rlim_reg <= LIMIT_RST;
         llim_reg <= LIMIT_RST;
      end else if (wr_stb) begin
         case (ptr_reg)
            OFS_CONFIG:       cfg_reg  <= wdata_reg;
            OFS_MASK:         mask_reg <= wdata_reg;
            OFS_FAN_SPEED:    fan_reg  <= wdata_reg;
            OFS_REMOTE_LIMIT: rlim_reg <= wdata_reg;
            OFS_LOCAL_LIMIT:  llim_reg <= wdata_reg;
            default:          ;
         endcase
      end
   end

   always_comb begin
      case (ptr_reg)
         OFS_REMOTE_TEMP:  rdata = rtemp_reg;
         OFS_LOCAL_TEMP:   rdata = ltemp_reg;
         OFS_REMOTE_LIMIT: rdata = rlim_reg;
         OFS_LOCAL_LIMIT:  rdata = llim_reg;
         OFS_FAN_SPEED:    rdata = fan_reg;
         OFS_CONFIG:       rdata = cfg_reg;
         OFS_MASK:         rdata = mask_reg;
         OFS_STATUS:       rdata = {3'h0, s_gin ^ cfg_reg[CFG_GIN_INV], stat_reg};
         default:          rdata = 8'h00;
      endcase
   end

   // SMBus slave
   tmfr_smb_e  smb_reg;
   logic       scl_d_reg, sda_d_reg, rw_reg, sda_oe_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic       scl_rise, scl_fall, start_c, stop_c;
   assign scl_rise = s_scl && !scl_d_reg;
   assign scl_fall = !s_scl && scl_d_reg;
   assign start_c  = s_scl && scl_d_reg && sda_d_reg && !s_sda;
   assign stop_c   = s_scl && scl_d_reg && !sda_d_reg && s_sda;

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         smb_reg     <= SMB_IDLE;
         scl_d_reg   <= 1'b1;
         sda_d_reg   <= 1'b1;
         rw_reg      <= 1'b0;
         sda_oe_reg  <= 1'b0;
         bit_cnt_reg <= 4'h0;
         shift_reg   <= 8'h00;
         ptr_reg     <= 8'h00;
         wdata_reg   <= 8'h00;
         wr_stb      <= 1'b0;
         rd_stb      <= 1'b0;
      end else begin
         scl_d_reg <= s_scl;
         sda_d_reg <= s_sda;
         wr_stb    <= 1'b0;
         rd_stb    <= 1'b0;
         if (start_c) begin
            smb_reg     <= SMB_ADDR;
            bit_cnt_reg <= 4'h0;
            sda_oe_reg  <= 1'b0;
         end else if (stop_c) begin
            smb_reg    <= SMB_IDLE;
            sda_oe_reg <= 1'b0;
         end else if (scl_rise) begin
            if (smb_reg == SMB_ADDR || smb_reg == SMB_PTR || smb_reg == SMB_WR) begin
               shift_reg   <= {shift_reg[6:0], s_sda};
               bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (smb_reg == SMB_RD_ACK) begin
               rw_reg <= !s_sda;
            end
         end else if (scl_fall) begin
            case (smb_reg)
               SMB_ADDR: if (bit_cnt_reg == 4'h8) begin
                  if (shift_reg[7:1] == {SMB_ADDR_HI, 1'b0, addr_lsb_reg} && strap_done_reg
                      && !test_mode_reg) begin
                     smb_reg    <= SMB_ADDR_ACK;
                     rw_reg     <= shift_reg[0];
                     sda_oe_reg <= 1'b1;
                  end else begin
                     smb_reg <= SMB_IDLE;
                  end
               end
               SMB_ADDR_ACK, SMB_RD_ACK: begin
                  bit_cnt_reg <= 4'h0;
                  if (!rw_reg) begin
                     smb_reg    <= (smb_reg == SMB_RD_ACK) ? SMB_IDLE : SMB_PTR;
                     sda_oe_reg <= 1'b0;
                  end else begin
                     smb_reg     <= SMB_RD;
                     shift_reg   <= rdata;
                     sda_oe_reg  <= !rdata[7];
                     bit_cnt_reg <= 4'h1;
                     rd_stb      <= 1'b1;
                  end
               end
               SMB_PTR: if (bit_cnt_reg == 4'h8) begin
                  smb_reg    <= SMB_PTR_ACK;
                  ptr_reg    <= shift_reg;
                  sda_oe_reg <= 1'b1;
               end
               SMB_PTR_ACK, SMB_WR_ACK: begin
                  smb_reg     <= SMB_WR;
                  bit_cnt_reg <= 4'h0;
                  sda_oe_reg  <= 1'b0;
               end
               SMB_WR: if (bit_cnt_reg == 4'h8) begin
                  smb_reg    <= SMB_WR_ACK;
                  wdata_reg  <= shift_reg;
                  wr_stb     <= 1'b1;
                  sda_oe_reg <= 1'b1;
               end
               SMB_RD: begin
                  if (bit_cnt_reg == 4'h8) begin
                     smb_reg    <= SMB_RD_ACK;
                     sda_oe_reg <= 1'b0;
                  end else begin
                     shift_reg   <= {shift_reg[6:0], 1'b0};
                     sda_oe_reg  <= !shift_reg[6];
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // Supervisors
   tmfr_rst_if aux_if ();
   tmfr_rst_if main_if ();
   assign aux_if.req  = !s_aux_ok;
   assign main_if.req = !s_main_ok || !s_man_n || !s_aux_n || aux_if.active;

   tmfr_reset_stretch #(.HOLD_CYCLES(RST_CYCLES_P)) u_aux_stretch (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .rif    (aux_if)
   );
   tmfr_reset_stretch #(.HOLD_CYCLES(RST_CYCLES_P)) u_main_stretch (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .rif    (main_if)
   );

   // Output pins
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sda_out                 <= 1'b0;
         sda_oe_out              <= 1'b0;
         overtemp_alarm_n_out    <= 1'b0;
         overtemp_alarm_n_oe_out <= 1'b0;
         fan_speed_dac_out       <= DAC_ZERO;
         fan_dac_oe_out          <= 1'b0;
         fan_off_n_out           <= 1'b1;
         int_n_out               <= 1'b1;
         addr_strap_test_out     <= 1'b0;
         addr_strap_test_oe_out  <= 1'b0;
         aux_reset_n_out         <= 1'b0;
         aux_reset_n_oe_out      <= 1'b1;
         main_reset_n_out        <= 1'b0;
      end else begin
         sda_oe_out              <= sda_oe_reg;
         overtemp_alarm_n_oe_out <= alarm_oe_reg;
         if (main_if.active) begin
            fan_speed_dac_out <= alarm_low ? DAC_FULL : DAC_ZERO;
         end else if (alarm_low || def_trip) begin
            fan_speed_dac_out <= DAC_FULL;
         end else begin
            fan_speed_dac_out <= fan_reg;
         end
         fan_dac_oe_out         <= strap_done_reg && !test_mode_reg;
         fan_off_n_out          <= cfg_reg[CFG_FAN_ON];
         int_n_out              <= !(cfg_reg[CFG_INT_EN] &&
                                     |(stat_reg & ~mask_reg[ST_EVENTS-1:0]));
         addr_strap_test_oe_out <= test_mode_reg;
         addr_strap_test_out    <= !(s_scl & s_sda & s_alarm_n & s_man_n & s_aux_n &
                                     s_gin);
         aux_reset_n_oe_out     <= aux_if.active;
         main_reset_n_out       <= !main_if.active;
      end
   end
endmodule

// *** bench/tmfr_checker.sv ***
module tmfr_checker
   import tmfr_pkg::*;
#(
   parameter int         CONV_CYCLES_P = CONV_CYCLES,
   parameter int         RST_CYCLES_P  = RST_CYCLES,
   parameter logic [7:0] DEF_LIMIT_P   = DEF_LIMIT
) (
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   // Watched pins
   input  wire logic [7:0] remote_temp_in,
   input  wire logic [7:0] local_temp_in,
   input  wire logic       overtemp_alarm_n_in,
   input  wire logic       overtemp_alarm_n_oe_out,
   input  wire logic [7:0] fan_speed_dac_out,
   input  wire logic       main_supply_monitor_in,
   input  wire logic       aux_supply_in,
   input  wire logic       manual_reset_n_in,
   input  wire logic       aux_reset_n_in,
   input  wire logic       aux_reset_n_oe_out,
   input  wire logic       main_reset_n_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   logic trip;
   logic ok;
   int   trip_cnt;
   int   ok_cnt;
   int   aux_cnt;
   assign trip = $signed(remote_temp_in) > $signed(DEF_LIMIT_P) ||
                 $signed(local_temp_in) > $signed(DEF_LIMIT_P);
   assign ok = main_supply_monitor_in && manual_reset_n_in && aux_reset_n_in;
   // Run lengths of each condition
   always_ff @(posedge clk_in) trip_cnt <= (rst_in || !trip) ? 0 : trip_cnt + 1;
   always_ff @(posedge clk_in) ok_cnt <= (rst_in || !ok) ? 0 : ok_cnt + 1;
   always_ff @(posedge clk_in) aux_cnt <= (rst_in || !aux_supply_in) ? 0 : aux_cnt + 1;
   sequence s_rst_cool;
      (!main_reset_n_out && overtemp_alarm_n_in) [*4];
   endsequence
   sequence s_rst_hot;
      (!main_reset_n_out && !overtemp_alarm_n_in) [*4];
   endsequence
   sequence s_ext_hot;
      (!overtemp_alarm_n_in) [*4];
   endsequence
   a_rst_fan_zero: assert property (s_rst_cool |-> fan_speed_dac_out == DAC_ZERO)
      else $error("fan code not zero in reset");
   a_rst_fan_full: assert property (s_rst_hot |=> fan_speed_dac_out == DAC_FULL)
      else $error("fan code not full in reset with alarm");
   a_ext_alarm_full: assert property (s_ext_hot |=> fan_speed_dac_out == DAC_FULL)
      else $error("fan code not full with alarm low");
   a_alarm_three_ticks: assert property ($rose(overtemp_alarm_n_oe_out)
      |-> trip_cnt >= 2 * CONV_CYCLES_P) else $error("alarm before three trips");
   a_main_rst_follow: assert property (!ok |-> ##[1:5] !main_reset_n_out)
      else $error("main reset missing");
   a_main_rst_hold: assert property ($rose(main_reset_n_out)
      |-> ok_cnt >= RST_CYCLES_P) else $error("main reset released early");
   a_main_rst_release: assert property (ok_cnt == RST_CYCLES_P + 6
      |-> main_reset_n_out) else $error("main reset held too long");
   a_aux_rst_follow: assert property (!aux_supply_in |-> ##[1:5] aux_reset_n_oe_out)
      else $error("aux reset missing");
   a_aux_rst_hold: assert property ($fell(aux_reset_n_oe_out)
      |-> aux_cnt >= RST_CYCLES_P) else $error("aux reset released early");
endmodule

bind tmfr_top tmfr_checker #(
   .CONV_CYCLES_P (CONV_CYCLES_P),
   .RST_CYCLES_P  (RST_CYCLES_P),
   .DEF_LIMIT_P   (DEF_LIMIT_P)
) chk_u (
   .clk_in, .rst_in, .remote_temp_in, .local_temp_in, .overtemp_alarm_n_in,
   .overtemp_alarm_n_oe_out, .fan_speed_dac_out, .main_supply_monitor_in,
   .aux_supply_in, .manual_reset_n_in, .aux_reset_n_in, .aux_reset_n_oe_out,
   .main_reset_n_out
);

// *** bench/tmfr_smb_host.sv ***
module tmfr_smb_host (
   // Clock
   input  wire logic clk_in,
   // Device pull on the data line
   input  wire logic sda_oe_in,
   // Bus levels
   output logic      scl_out,
   output logic      sda_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic scl_q = 1'b1;
   logic sda_q = 1'b1;
   // Wired-AND with pull-up
   assign scl_out = scl_q;
   assign sda_out = sda_q & ~sda_oe_in;
   task automatic pace();
      repeat (5) @(negedge clk_in);
   endtask
   task automatic clk_bit(input logic b, output logic r);
      pace();
      sda_q = b;
      pace();
      scl_q = 1'b1;
      pace();
      r = sda_out;
      pace();
      scl_q = 1'b0;
   endtask
   // Also serves as repeated start
   task automatic start();
      pace();
      sda_q = 1'b1;
      pace();
      scl_q = 1'b1;
      pace();
      sda_q = 1'b0;
      pace();
      scl_q = 1'b0;
   endtask
   task automatic stop();
      pace();
      sda_q = 1'b0;
      pace();
      scl_q = 1'b1;
      pace();
      sda_q = 1'b1;
      pace();
   endtask
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic nak);
      for (int i = 7; i >= 0; i--)
         clk_bit(tx[i], rx[i]);
      clk_bit(1'b1, nak);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                     output logic nak);
      logic [7:0] rx;
      logic       n0;
      logic       n1;
      logic       n2;
      start();
      xfer({a, 1'b0}, rx, n0);
      xfer(p, rx, n1);
      xfer(d, rx, n2);
      stop();
      nak = n0 | n1 | n2;
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d);
      logic [7:0] rx;
      logic       n;
      start();
      xfer({a, 1'b0}, rx, n);
      xfer(p, rx, n);
      start();
      xfer({a, 1'b1}, rx, n);
      xfer(8'hff, d, n);
      stop();
   endtask
endmodule

// *** bench/tb_tmfr_top.sv ***
module tb_tmfr_top
   import tmfr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int         CONV = 50;
   localparam int         RST  = 20;
   localparam logic [6:0] ADDR = {SMB_ADDR_HI, 2'b01};
   logic       clk_in  = 1'b0;
   logic       rst_in  = 1'b1;
   logic [7:0] rtemp   = 8'hf0;
   logic [7:0] ltemp   = 8'h10;
   logic       al_ext  = 1'b1;
   logic       test_in = 1'b0;
   logic       gin     = 1'b0;
   logic       strap   = 1'b1;
   logic       vmain   = 1'b1;
   logic       vaux    = 1'b1;
   logic       man_n   = 1'b1;
   logic       aux_ext = 1'b1;
   logic       scl, sda, sda_oe, al_oe, fan_oe, fan_off_n, int_n;
   logic       tst_out, tst_oe, aux_oe, main_n, al_w, aux_w, n1;
   logic       sda_lo, al_lo, aux_lo;
   logic [7:0] fan, f, seen;
   logic [7:0] exp_q[$];
   int         n, err_total, check_count;
   int         seed    = 62;
   event       seen_ev;
   // Open-drain pins resolved with pull-ups
   assign al_w  = al_ext & ~al_oe;
   assign aux_w = aux_ext & ~aux_oe;
   tmfr_top #(.CONV_CYCLES_P(CONV), .RST_CYCLES_P(RST)) dut_u (
      .clk_in, .rst_in, .remote_temp_in(rtemp), .local_temp_in(ltemp),
      .scl_in(scl), .sda_in(sda), .sda_out(sda_lo), .sda_oe_out(sda_oe),
      .overtemp_alarm_n_in(al_w), .overtemp_alarm_n_out(al_lo), .overtemp_alarm_n_oe_out(al_oe),
      .fan_speed_dac_out(fan), .fan_dac_oe_out(fan_oe), .fan_dac_test_in(test_in),
      .fan_off_n_out(fan_off_n), .int_n_out(int_n), .general_input_in(gin),
      .addr_strap_test_in(tst_oe ? tst_out : strap), .addr_strap_test_out(tst_out),
      .addr_strap_test_oe_out(tst_oe), .main_supply_monitor_in(vmain),
      .aux_supply_in(vaux), .manual_reset_n_in(man_n), .aux_reset_n_in(aux_w),
      .aux_reset_n_out(aux_lo), .aux_reset_n_oe_out(aux_oe), .main_reset_n_out(main_n)
   );
   tmfr_smb_host host_u (.clk_in, .sda_oe_in(sda_oe), .scl_out(scl), .sda_out(sda));
   initial forever #25 clk_in = ~clk_in;
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      check_count++;
      if (s !== e) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // Note the expectation, then hand the result to the watcher
   task automatic obs(input logic [7:0] s, input logic [7:0] e);
      exp_q.push_back(e);
      seen = s;
      -> seen_ev;
      #1;
   endtask
   initial forever begin
      @(seen_ev);
      chk(seen, exp_q.pop_front());
   end
   task automatic cyc(input int c);
      repeat (c) @(negedge clk_in);
   endtask
   task automatic rd(input logic [7:0] p, input logic [7:0] e);
      logic [7:0] d;
      host_u.rd(ADDR, p, d);
      obs(d, e);
   endtask
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      logic k;
      host_u.wr(ADDR, p, d, k);
      obs({7'h00, k}, 8'h00);
   endtask
   task automatic wait_main(output int c);
      c = 0;
      while (main_n !== 1'b1 && c < 400) begin
         @(negedge clk_in);
         c++;
      end
   endtask
   task automatic report_and_stop();
      $display("Checks %0d, mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #(50 * 60000);
      err_total++;
      report_and_stop();
   end
   initial begin
      cyc(4);
      rst_in = 1'b0;
      wait_main(n);
      cyc(3 * CONV);
      rd(OFS_CONFIG, CONFIG_RST);
      rd(OFS_REMOTE_TEMP, 8'hf0);
      rd(OFS_STATUS, 8'h00);
      rd(8'h55, 8'h00);
      host_u.wr(ADDR ^ 7'h01, OFS_CONFIG, 8'h00, n1);
      obs({7'h00, n1}, 8'h01);
      f = 8'($random(seed));
      wr(OFS_FAN_SPEED, f);
      wr(OFS_CONFIG, 8'h00);
      cyc(4);
      obs({7'h00, fan_off_n}, 8'h00);
      obs(fan, f);
      for (int k = 0; k < 4; k++) begin
         gin = k[0];
         wr(OFS_CONFIG, {1'b0, k[1], 6'h20});
         rd(OFS_STATUS, {3'h0, k[0] ^ k[1], 4'h0});
      end
      gin = 1'b0;
      wr(OFS_REMOTE_LIMIT, 8'h30);
      rtemp = 8'h31;
      cyc(2 * CONV);
      obs({7'h00, int_n}, 8'h01);
      wr(OFS_CONFIG, 8'h22);
      cyc(3);
      obs({7'h00, int_n}, 8'h00);
      obs({7'h00, fan_off_n}, 8'h01);
      wr(OFS_MASK, 8'h01);
      rd(OFS_STATUS, 8'h01);
      cyc(3);
      obs({7'h00, int_n}, 8'h01);
      ltemp = 8'h56;
      n = 0;
      while (al_oe !== 1'b1 && n < 4 * CONV) begin
         @(negedge clk_in);
         n++;
      end
      obs({7'h00, n >= 2 * CONV && n <= 3 * CONV + 5}, 8'h01);
      obs(fan, DAC_FULL);
      ltemp = 8'h10;
      cyc(CONV + 4);
      obs({7'h00, al_oe}, 8'h00);
      obs(fan, f);
      rd(OFS_STATUS, 8'h07);
      al_ext = 1'b0;
      cyc(6);
      obs(fan, DAC_FULL);
      al_ext = 1'b1;
      cyc(6);
      obs(fan, f);
      rd(OFS_STATUS, 8'h09);
      for (int k = 0; k < 4; k++) begin
         vmain = (k != 0);
         man_n = (k != 1);
         vaux = (k != 2);
         aux_ext = (k != 3);
         cyc(10);
         obs({7'h00, main_n}, 8'h00);
         obs({7'h00, aux_oe}, {7'h00, k == 2});
         obs(fan, DAC_ZERO);
         al_ext = 1'b0;
         cyc(6);
         obs(fan, DAC_FULL);
         al_ext = 1'b1;
         {vmain, man_n, vaux, aux_ext} = 4'hf;
         wait_main(n);
         obs({7'h00, n >= RST && n <= (k == 2 ? 2 * RST : RST) + 10}, 8'h01);
      end
      test_in = 1'b1;
      gin = 1'b1;
      rst_in = 1'b1;
      cyc(4);
      rst_in = 1'b0;
      cyc(RST + 10);
      obs({6'h00, tst_oe, fan_oe}, 8'h02);
      obs({7'h00, tst_out}, 8'h00);
      gin = 1'b0;
      cyc(5);
      obs({7'h00, tst_out}, 8'h01);
      test_in = 1'b0;
      rst_in = 1'b1;
      cyc(4);
      rst_in = 1'b0;
      cyc(8);
      obs({6'h00, tst_oe, fan_oe}, 8'h01);
      obs({5'h00, sda_lo, al_lo, aux_lo}, 8'h00);
      report_and_stop();
   end
endmodule
